/* File: pspsr_pkg.sv */
/*
 * Package for the pipelined synchronous SRAM port: widths, burst codes,
 * pipeline state and the carrier structs shared by the port and its array.
 * Assumes a single 25 MHz clock and a synchronous active-low reset.
 */
package pspsr_pkg;

    // ****************************************
    // Sizes
    // ****************************************
    localparam int PSPSR_LANES = 4;
    localparam int PSPSR_LANE_W = 8;
    localparam int PSPSR_ADDR_W = 6;
    localparam int PSPSR_BURST_W = 2;
    localparam real PSPSR_CLK_MHZ = 25.0;

    localparam logic PSPSR_ORDER_INTERLEAVED = 1'h1;
    localparam logic PSPSR_ORDER_LINEAR = 1'h0;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [1:0] {
        PSPSR_DESEL = 2'h0,
        PSPSR_FIRST = 2'h1,
        PSPSR_ACTIVE = 2'h3
    } pspsr_sel_e;

    typedef struct packed {
        logic chip_enable_first_n;
        logic chip_enable_second;
        logic chip_enable_third_n;
        logic write_enable_n;
        logic advance_or_load;
        logic [PSPSR_LANES-1:0] byte_write_select_n;
        logic [PSPSR_ADDR_W-1:0] address_inputs;
    } pspsr_cmd_s;

    typedef struct packed {
        logic we;
        logic [PSPSR_LANES-1:0] lane_we;
        logic [PSPSR_ADDR_W-1:0] addr;
        logic [PSPSR_LANES*PSPSR_LANE_W-1:0] data;
        logic [PSPSR_LANES-1:0] parity;
    } pspsr_wr_s;

endpackage

/* File: pspsr_array.sv */
/*
 * Flip-flop storage array with per-lane write gating and registered read.
 * Assumes the port hands it a qualified write and a read index each cycle.
 */
`timescale 1ns/1ns
module pspsr_array
    import pspsr_pkg::*;
#(
    parameter int DEPTH = 2**PSPSR_ADDR_W
) (
    input wire logic clk, // System clock
    input wire logic hold, // Clock enable deasserted
    input wire pspsr_wr_s wr, // Write request
    input wire logic [PSPSR_ADDR_W-1:0] rd_addr, // Read index
    output logic [PSPSR_LANES*(PSPSR_LANE_W+1)-1:0] rd_word // Registered read word
);
    if (DEPTH > 2**PSPSR_ADDR_W || DEPTH < 1) begin : g_bad_depth
        $error("pspsr_array: bad DEPTH");
    end

    typedef struct packed {
        logic [DEPTH-1:0][PSPSR_LANES-1:0][PSPSR_LANE_W:0] mem;
        logic [PSPSR_LANES*(PSPSR_LANE_W+1)-1:0] rd;
    } pspsr_arr_s;

    pspsr_arr_s st_q;
    pspsr_arr_s st_d;

    always_comb begin
        st_d = st_q;
        if (!hold) begin
            st_d.rd = st_q.mem[rd_addr];
            if (wr.we) begin
                for (int i = 0; i < PSPSR_LANES; i++) begin
                    if (wr.lane_we[i]) begin
                        st_d.mem[wr.addr][i] = {wr.parity[i],
                                                wr.data[i*PSPSR_LANE_W +: PSPSR_LANE_W]};
                    end
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        st_q <= st_d;
    end

    assign rd_word = st_q.rd;
endmodule // pspsr_array

/* File: pspsr_port.sv */
/*
 * Pipelined synchronous burst SRAM port: chip select decode, clock-enable
 * suspend, burst address counter, write data pipeline and output-enable
 * masking of the data and parity lanes.
 * Assumes all inputs but output_enable_n synchronous to clk; the bidirectional lanes are split
 * into in, out and enable, resolved outside.
 */
// Summary of operation
// - First chip enable is active low, sampled on rising edge, used for selection.
// - Second chip enable is active high, sampled on rising edge, used for selection.
// - Output enable low and internal control allow: drive data and parity lanes.
// - Output enable high: lanes in high impedance, serving as inputs.
// - Outputs off in write data phase, first clock after deselect, and deselected.
// - Edges act only while clock gate is low; a gated edge still applies reset, takes the strap once after reset, and drops a write due into the array.
// - Clock gate high holds state, except the array write strobe, which clears, and the strap capture after reset; extends the cycle, never deselects.
// - Input lanes captured into data register on rising edge.
// - Read data appears one cycle after the address edge, pipelined.
// - Burst-order strap high selects interleaved, low selects linear.
// - Strap left floating behaves as high, interleaved.
// - Advance high steps burst counter; low loads new address.
// - Each byte write select with write enable gates its lane and parity.
`timescale 1ns/1ns
module pspsr_port
    import pspsr_pkg::*;
#(
    parameter int DEPTH = 2**PSPSR_ADDR_W
) (
    input wire logic clk, // System clock
    input wire logic rstn, // Synchronous reset, active low
    input wire logic clock_gate_n, // Clock enable, active low
    input wire pspsr_cmd_s cmd, // Synchronous control and address
    input wire logic output_enable_n, // Asynchronous output enable
    input wire logic burst_order_strap, // High interleaved, low linear
    input wire logic [PSPSR_LANES*PSPSR_LANE_W-1:0] data_lanes_in, // Data lanes in
    input wire logic [PSPSR_LANES-1:0] parity_lanes_in, // Parity lanes in
    output logic [PSPSR_LANES*PSPSR_LANE_W-1:0] data_lanes_out, // Data lanes out
    output logic [PSPSR_LANES-1:0] parity_lanes_out, // Parity lanes out
    output logic lanes_oe // Lanes driven
);
    localparam int WORD_W = PSPSR_LANES * (PSPSR_LANE_W + 1);

    if (PSPSR_BURST_W > PSPSR_ADDR_W) begin : g_bad_burst
        $error("pspsr_port: burst wider than address");
    end

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        pspsr_sel_e sel;
        logic order;
        logic strap_taken;
        logic [PSPSR_ADDR_W-1:0] base;
        logic [PSPSR_BURST_W-1:0] cnt;
        logic rd_p1; // Read address edge seen
        logic rd_p2; // Read data on lanes
        logic wr_p1; // Write address edge seen
        logic [PSPSR_ADDR_W-1:0] wr_addr;
        logic [PSPSR_LANES-1:0] wr_lanes;
        logic wr_p2; // Write data phase
        pspsr_wr_s wr;
    } pspsr_port_s;

    pspsr_port_s st_q;
    pspsr_port_s st_d;
    logic [WORD_W-1:0] rd_word;
    logic [PSPSR_ADDR_W-1:0] rd_addr;

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [PSPSR_BURST_W-1:0] burst_offs(
        input logic [PSPSR_BURST_W-1:0] start,
        input logic [PSPSR_BURST_W-1:0] n,
        input logic order
    );
        if (order == PSPSR_ORDER_INTERLEAVED) begin
            burst_offs = start ^ n;
        end else begin
            burst_offs = start + n;
        end
    endfunction

    function automatic logic [PSPSR_ADDR_W-1:0] burst_addr(
        input logic [PSPSR_ADDR_W-1:0] base,
        input logic [PSPSR_BURST_W-1:0] n,
        input logic order
    );
        burst_addr = {base[PSPSR_ADDR_W-1:PSPSR_BURST_W],
                      burst_offs(base[PSPSR_BURST_W-1:0], n, order)};
    endfunction

    // ****************************************
    // Next state
    // ****************************************
    logic selected;
    logic [PSPSR_ADDR_W-1:0] acc_addr;
    logic access;
    logic is_write;

    always_comb begin
        st_d = st_q;
        selected = !cmd.chip_enable_first_n
                   && cmd.chip_enable_second
                   && !cmd.chip_enable_third_n;
        acc_addr = cmd.address_inputs;
        access = 1'b0;
        is_write = 1'b0;
        // Strap is taken once after reset; a floating pin resolves high outside.
        if (!st_q.strap_taken) begin
            st_d.order = burst_order_strap;
            st_d.strap_taken = 1'b1;
        end
        st_d.wr.we = 1'b0;
        if (!clock_gate_n) begin
            if (!cmd.advance_or_load) begin
                access = selected;
                acc_addr = cmd.address_inputs;
                is_write = !cmd.write_enable_n;
                st_d.base = cmd.address_inputs;
                st_d.cnt = '0;
            end else if (st_q.sel != PSPSR_DESEL) begin
                // Continue the burst in the direction of the last access
                access = 1'b1;
                is_write = st_q.wr_p1 | (st_q.wr_p2 & !st_q.rd_p1);
                st_d.cnt = st_q.cnt + 1'b1;
                acc_addr = burst_addr(st_q.base, st_d.cnt, st_q.order);
            end
            unique case (st_q.sel)
                PSPSR_DESEL: st_d.sel = access ? PSPSR_FIRST : PSPSR_DESEL;
                PSPSR_FIRST: st_d.sel = access ? PSPSR_ACTIVE : PSPSR_DESEL;
                PSPSR_ACTIVE: st_d.sel = access ? PSPSR_ACTIVE : PSPSR_DESEL;
                default: st_d.sel = PSPSR_DESEL;
            endcase
            st_d.rd_p1 = access && !is_write;
            st_d.rd_p2 = st_q.rd_p1;
            st_d.wr_p1 = access && is_write;
            st_d.wr_addr = acc_addr;
            st_d.wr_lanes = ~cmd.byte_write_select_n;
            st_d.wr_p2 = st_q.wr_p1;
            if (st_q.wr_p1) begin
                st_d.wr.we = 1'b1;
                st_d.wr.addr = st_q.wr_addr;
                st_d.wr.lane_we = st_q.wr_lanes;
                st_d.wr.data = data_lanes_in;
                st_d.wr.parity = parity_lanes_in;
            end
        end
        if (!rstn) begin
            st_d = '0;
            st_d.order = PSPSR_ORDER_INTERLEAVED;
        end
    end

    always_ff @(posedge clk) begin
        st_q <= st_d;
    end

    // Read index is the address held from the access edge, so the word
    // lands one enabled edge later and stays put while gated.
    assign rd_addr = st_q.wr_addr;

    pspsr_array #(
        .DEPTH(DEPTH)
    ) u_array (
        .clk(clk),
        .hold(clock_gate_n),
        .wr(st_q.wr),
        .rd_addr(rd_addr),
        .rd_word(rd_word)
    );

    // ****************************************
    // Lane drive
    // ****************************************
    always_comb begin
        for (int i = 0; i < PSPSR_LANES; i++) begin
            data_lanes_out[i*PSPSR_LANE_W +: PSPSR_LANE_W] =
                rd_word[i*(PSPSR_LANE_W+1) +: PSPSR_LANE_W];
            parity_lanes_out[i] = rd_word[i*(PSPSR_LANE_W+1) + PSPSR_LANE_W];
        end
    end

    // Output enable is asynchronous by nature, so it gates the drive directly.
    assign lanes_oe = !output_enable_n
                      && st_q.rd_p2
                      && !st_q.wr_p2
                      && st_q.sel == PSPSR_ACTIVE;
endmodule // pspsr_port

/* File: pspsr_ctrl_model.sv */
/* Controller stand-in: puts commands on the port pins and write data on
   the lanes for the one data cycle. Paced by the bench on rising edges. */
`timescale 1ns/1ns
module pspsr_ctrl_model
    import pspsr_pkg::*;
(
    input wire logic clk, // Clock
    input wire logic rstn, // Reset
    input wire logic clock_gate_n, // Clock enable
    input wire pspsr_cmd_s req, // Command asked
    input wire logic [35:0] wword, // Parity and data to write
    output pspsr_cmd_s cmd, // Command pins
    output logic [35:0] lanes // Parity and data driven
);
    assign cmd = req;
    // Undriven lanes flip, so stale data cannot pass as written
    always_ff @(posedge clk) begin
        if (!rstn) begin
            lanes <= '0;
        end else if (!clock_gate_n) begin
            lanes <= (!req.write_enable_n && !req.advance_or_load) ? wword : ~lanes;
        end
    end
endmodule // pspsr_ctrl_model

/* File: pspsr_port_monitor.sv */
/* Checker of lane drive and output hold at the port pins.
   Bound into pspsr_port at the foot of this file. */
`timescale 1ns/1ns
module pspsr_port_monitor
    import pspsr_pkg::*;
(
    input wire logic clk, // Clock
    input wire logic rstn, // Reset
    input wire logic clock_gate_n, // Clock enable
    input wire pspsr_cmd_s cmd, // Command
    input wire logic output_enable_n, // Output enable
    input wire logic [PSPSR_LANES*PSPSR_LANE_W-1:0] data_lanes_out, // Data
    input wire logic [PSPSR_LANES-1:0] parity_lanes_out, // Parity
    input wire logic lanes_oe // Drive
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    logic en, ld, sel;
    assign en = !clock_gate_n;
    assign ld = en && !cmd.advance_or_load;
    assign sel = !cmd.chip_enable_first_n && cmd.chip_enable_second && !cmd.chip_enable_third_n;
    sequence off_s; ld && !sel; endsequence
    sequence rd_s; ld && sel && cmd.write_enable_n; endsequence
    sequence wr_s; ld && sel && !cmd.write_enable_n; endsequence
    oe_high_off_a: assert property (output_enable_n |-> !lanes_oe)
        else $error("drive with enable high");
    desel_off_a: assert property (off_s ##1 en |=> !lanes_oe)
        else $error("drive after deselect");
    first_clock_a: assert property (off_s ##1 rd_s |=> !lanes_oe)
        else $error("drive on first clock");
    desel_mask_a: assert property (rd_s ##1 off_s |=> !lanes_oe)
        else $error("drive while deselected");
    write_off_a: assert property (wr_s ##1 en |=> !lanes_oe)
        else $error("drive in write data");
    read_drive_a: assert property (rd_s ##1 rd_s ##1 (en && !(ld && !sel)) ##1 !output_enable_n
        |-> lanes_oe)
        else $error("read not driven");
    gate_hold_a: assert property (clock_gate_n |=> $stable({parity_lanes_out, data_lanes_out}))
        else $error("data moved while gated");
    gate_keep_a: assert property (clock_gate_n ##1 $stable(output_enable_n) |-> $stable(lanes_oe))
        else $error("drive moved while gated");
    desel_adv_a: assert property (off_s ##1 (en && cmd.advance_or_load) ##1 en |=> !lanes_oe)
        else $error("advance left deselect");
endmodule // pspsr_port_monitor
bind pspsr_port pspsr_port_monitor u_mon (.clk, .rstn, .clock_gate_n, .cmd, .output_enable_n,
    .data_lanes_out, .parity_lanes_out, .lanes_oe);

/* File: pipelined_sync_sram_port_tb.sv */
/* Bench for the SRAM port driven through the controller model.
   Assumes package, port, array, model and checker compiled first. */
`timescale 1ns/1ns
module pipelined_sync_sram_port_tb;
    import pspsr_pkg::*;
    logic clk, rstn, clock_gate_n, output_enable_n, burst_order_strap, lanes_oe;
    pspsr_cmd_s req, cmd;
    logic [35:0] wword, lanes, e;
    logic [31:0] data_lanes_out;
    logic [3:0] parity_lanes_out;
    int mismatches, samples_checked;
    pspsr_ctrl_model i_pspsr_ctrl_model (.clk, .rstn, .clock_gate_n, .req, .wword, .cmd, .lanes);
    pspsr_port i_pspsr_port (.clk, .rstn, .clock_gate_n, .cmd, .output_enable_n,
        .burst_order_strap, .data_lanes_in(lanes[31:0]), .parity_lanes_in(lanes[35:32]),
        .data_lanes_out, .parity_lanes_out, .lanes_oe);
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic chk(string n, logic [35:0] seen, logic [35:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s exp %h seen %h", n, exp, seen);
        end
    endtask
    function automatic pspsr_cmd_s mk(logic [2:0] c, logic w, logic v, logic [3:0] b, int a);
        return '{c[2], c[1], c[0], w, v, b, a[5:0]};
    endfunction
    function automatic pspsr_cmd_s rd(int a);
        return mk(3'h2, 1'b1, 1'b0, 4'hf, a);
    endfunction
    function automatic logic [35:0] wd(int a);
        return {a[3:0], 24'h9abcde, a[7:0]};
    endfunction
    task automatic step(pspsr_cmd_s c, logic [35:0] w = '0, logic g = 1'b0, logic o = 1'b0);
        @(posedge clk);
        req <= c;
        wword <= w;
        clock_gate_n <= g;
        output_enable_n <= o;
    endtask
    task automatic look(string n, logic o, logic [35:0] d);
        @(negedge clk);
        chk(n, 36'(lanes_oe), 36'(o));
        if (o) chk(n, {parity_lanes_out, data_lanes_out}, d);
    endtask
    task automatic t_rw();
        e = (wd(2) & 36'h5_00ff_00ff) | (wd(1) & 36'ha_ff00_ff00);
        step(mk(3'h2, 1'b0, 1'b0, 4'h0, 5), wd(1));
        step(mk(3'h2, 1'b0, 1'b0, 4'ha, 5), wd(2));
        // Gap keeps the read clear of the write still retiring
        repeat (2) step(rd(7));
        repeat (3) step(rd(5));
        look("rw", 1'b1, e);
    endtask
    task automatic t_gate();
        repeat (3) begin
            step(mk(3'h2, 1'b0, 1'b0, 4'h0, 5), wd(3), 1'b1);
            look("hold", 1'b1, e);
        end
        repeat (3) step(rd(5));
        look("gated", 1'b1, e);
        step(rd(5), '0, 1'b0, 1'b1);
        look("oe_off", 1'b0, e);
        step(rd(5));
        look("oe_on", 1'b1, e);
    endtask
    task automatic t_desel();
        for (int i = 0; i < 3; i++) begin
            repeat (2) step(rd(5));
            step(mk(3'h2 ^ (3'h1 << i), 1'b1, 1'b0, 4'hf, 5));
            step(i == 0 ? mk(3'h2, 1'b1, 1'b1, 4'hf, 5) : rd(5));
            step(rd(5));
            look("desel", 1'b0, e);
            step(rd(5));
            look("next", i != 0, e);
            step(rd(5));
            look("first", 1'b1, e);
            step(rd(5));
            look("back", 1'b1, e);
        end
    endtask
    task automatic t_burst(logic s);
        @(posedge clk);
        rstn <= 1'b0;
        burst_order_strap <= s;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        for (int a = 4; a < 8; a++) step(mk(3'h2, 1'b0, 1'b0, 4'h0, a), wd(a));
        step(rd(5));
        step(mk(3'h2, 1'b1, 1'b1, 4'hf, 0));
        for (int k = 0; k < 4; k++) begin
            step(k < 2 ? mk(3'h2, 1'b1, 1'b1, 4'hf, 0) : rd(0));
            look("burst", 1'b1, wd(4 + ((s ? 1 ^ k : 1 + k) & 3)));
        end
    endtask
    task automatic end_of_test();
        if (mismatches == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        rstn = 1'b0;
        clock_gate_n = 1'b0;
        output_enable_n = 1'b0;
        burst_order_strap = 1'b1;
        req = mk(3'h4, 1'b1, 1'b0, 4'hf, 0);
        wword = '0;
        mismatches = 0;
        samples_checked = 0;
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        t_rw();
        t_gate();
        t_desel();
        t_burst(1'b1);
        t_burst(1'b0);
        end_of_test();
    end
endmodule // pipelined_sync_sram_port_tb
